// File: hw/rtsas_map.svh
// register map, field positions, reset values and timing figures
`ifndef RTSAS_MAP_SVH
`define RTSAS_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RTSAS_CTRL_OFS 8'h00
`define RTSAS_STAT_OFS 8'h04
`define RTSAS_IRQ_ST_OFS 8'h08
`define RTSAS_IRQ_MK_OFS 8'h0C

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define RTSAS_CTRL_SEL_LO 0
`define RTSAS_CTRL_SEL_HI 1
`define RTSAS_CTRL_CARRIER 2
`define RTSAS_CTRL_RST 3'h0
`define RTSAS_IRQ_STREAM 0
`define RTSAS_IRQ_BITERR 1
`define RTSAS_IRQ_RST 2'h0
`define RTSAS_STAT_RTS 0
`define RTSAS_STAT_TEST 1
`define RTSAS_STAT_DCD 2
`define RTSAS_STAT_STREAM 3
`define RTSAS_ZERO32 32'h0000_0000

// ----------------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------------
`define RTSAS_CLK_NS 25
`define RTSAS_TICK_NS 1000000
`define RTSAS_SHORT_MS 12500
`define RTSAS_LONG_MS 50000

`endif

// File: hw/rtsas_pkg.sv
// types shared by the anti-stream and indicator block
package rtsas_pkg;

  // timeout selection decoded from the two select bits
  typedef enum logic [1:0] {SEL_OFF, SEL_SHORT, SEL_LONG} rtsas_sel_t;

  // anti-stream timer states
  typedef enum logic [1:0] {TMR_IDLE, TMR_TIMING, TMR_STREAM} rtsas_tmr_t;

  // whole state of the block
  typedef struct packed {
    rtsas_tmr_t tmr;
    logic [15:0] presc;
    logic [15:0] ticks;
    logic [2:0] ctrl;
    logic [1:0] irq_st;
    logic [1:0] irq_mk;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic rts_out;
    logic dcd;
    logic tx_en;
    logic led_td;
    logic led_rd;
    logic led_rts;
    logic led_cd;
    logic led_test;
    logic led_err;
    logic irq;
  } rtsas_state_t;

endpackage : rtsas_pkg

// File: hw/rtsas_top.sv
// anti-stream timer, carrier control and front-panel indicators
//
// Functional notes
// - timer gates RTS only when enabled; disabled passes RTS untouched
// - timer starts when terminal raises RTS
// - RTS high past timeout forces internal RTS low
// - timeout lights error indicator red
// - RTS drop clears timer and turns error indicator off
// - timeout selectable between short and long period
// - during a test, error indicator shows bit errors
// - outside a test, error indicator shows streaming condition
// - test indicator on while pattern test or loopback runs
// - TD and RD indicators follow their lines, green high, red low
// - RTS and CD indicators green high, red low
// - carrier detect output and indicator follow line carrier
// - constant-carrier master keeps transmitter on always
// - RTS-controlled slave enables carrier only while gated RTS high
// - select decode: off/off off, off/on short, on/off long, on/on short
// - actual timeout not shorter than nominal, at most half longer
`timescale 1ns/10ps
`include "rtsas_map.svh"

module rtsas_top
  import rtsas_pkg::*;
#(
  parameter int PRESCALE = `RTSAS_TICK_NS / `RTSAS_CLK_NS,
  // tick count per period; ratio taken first so the product stays inside an int
  parameter int SHORT_TICKS = `RTSAS_SHORT_MS * (1000000 / `RTSAS_TICK_NS),
  parameter int LONG_TICKS = `RTSAS_LONG_MS * (1000000 / `RTSAS_TICK_NS)
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rts_dte_i,
  input wire logic txd_i,
  input wire logic rxd_i,
  input wire logic line_carrier_i,
  input wire logic ber_test_i,
  input wire logic loop_test_i,
  input wire logic bit_error_i,
  output logic rts_int_o,
  output logic dcd_o,
  output logic line_tx_en_o,
  output logic led_td_green_o,
  output logic led_rd_green_o,
  output logic led_rts_green_o,
  output logic led_cd_green_o,
  output logic led_test_o,
  output logic led_err_o,
  output logic irq_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  function automatic rtsas_sel_t sel_decode(input logic hi, input logic lo);
    if (!hi && !lo) begin
      return SEL_OFF;
    end else if (hi && !lo) begin
      return SEL_LONG;
    end
    return SEL_SHORT;
  endfunction : sel_decode

  function automatic logic [15:0] tick_limit(input rtsas_sel_t sel);
    return (sel == SEL_LONG) ? 16'(LONG_TICKS) : 16'(SHORT_TICKS);
  endfunction : tick_limit

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  rtsas_state_t s_q;
  rtsas_state_t s_d;
  rtsas_sel_t sel;
  logic [15:0] lim;
  logic hit;
  logic acc;
  logic commit;
  logic ev_stream;
  logic ev_biterr;
  logic [1:0] w1c;
  logic [31:0] rd_val;

  assign sel = sel_decode(s_q.ctrl[`RTSAS_CTRL_SEL_HI], s_q.ctrl[`RTSAS_CTRL_SEL_LO]);
  assign lim = tick_limit(sel);

  // address decode, shared by read and write
  assign hit = (paddr_i == `RTSAS_CTRL_OFS) || (paddr_i == `RTSAS_STAT_OFS) ||
               (paddr_i == `RTSAS_IRQ_ST_OFS) || (paddr_i == `RTSAS_IRQ_MK_OFS);
  assign acc = psel_i && penable_i && !s_q.pready;
  assign commit = psel_i && penable_i && s_q.pready && pwrite_i && hit;

  // read mux; status shows live block state
  always_comb begin
    rd_val = `RTSAS_ZERO32;
    if (paddr_i == `RTSAS_CTRL_OFS) begin
      rd_val[2:0] = s_q.ctrl;
    end else if (paddr_i == `RTSAS_STAT_OFS) begin
      rd_val[`RTSAS_STAT_RTS] = rts_dte_i;
      rd_val[`RTSAS_STAT_TEST] = s_q.led_test;
      rd_val[`RTSAS_STAT_DCD] = s_q.dcd;
      rd_val[`RTSAS_STAT_STREAM] = (s_q.tmr == TMR_STREAM);
    end else if (paddr_i == `RTSAS_IRQ_ST_OFS) begin
      rd_val[1:0] = s_q.irq_st;
    end else if (paddr_i == `RTSAS_IRQ_MK_OFS) begin
      rd_val[1:0] = s_q.irq_mk;
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ev_stream = 1'b0;
    w1c = 2'h0;

    // apb: answer one cycle into the access phase, commit on pready
    s_d.pready = acc;
    s_d.pslverr = acc && !hit;
    if (acc) begin
      s_d.prdata = rd_val;
    end
    if (commit) begin
      if (paddr_i == `RTSAS_CTRL_OFS) begin
        s_d.ctrl = pwdata_i[2:0];
      end else if (paddr_i == `RTSAS_IRQ_ST_OFS) begin
        w1c = pwdata_i[1:0];
      end else if (paddr_i == `RTSAS_IRQ_MK_OFS) begin
        s_d.irq_mk = pwdata_i[1:0];
      end
    end

    // anti-stream timer; a select change takes effect at once
    unique case (s_q.tmr)
      TMR_IDLE: begin
        if (sel != SEL_OFF && rts_dte_i) begin
          s_d.tmr = TMR_TIMING;
          s_d.presc = 16'h0000;
          s_d.ticks = 16'h0000;
        end
      end
      TMR_TIMING: begin
        if (!rts_dte_i || sel == SEL_OFF) begin
          s_d.tmr = TMR_IDLE;
        end else if (s_q.presc == 16'(PRESCALE - 1)) begin
          s_d.presc = 16'h0000;
          // prescaler restarts with RTS, so no early expiry
          if (s_q.ticks >= lim - 16'h0001) begin
            s_d.tmr = TMR_STREAM;
            ev_stream = 1'b1;
          end else begin
            s_d.ticks = s_q.ticks + 16'h0001;
          end
        end else begin
          s_d.presc = s_q.presc + 16'h0001;
        end
      end
      TMR_STREAM: begin
        // wait for the terminal to let go
        if (!rts_dte_i || sel == SEL_OFF) begin
          s_d.tmr = TMR_IDLE;
        end
      end
    endcase

    s_d.rts_out = rts_dte_i && (s_d.tmr != TMR_STREAM);
    // carrier follows gated RTS only in RTS-controlled mode
    s_d.tx_en = s_d.ctrl[`RTSAS_CTRL_CARRIER] ? s_d.rts_out : 1'b1;
    s_d.dcd = line_carrier_i;
    s_d.led_cd = line_carrier_i;
    // bicolour indicators: 1 is green, 0 is red
    s_d.led_td = txd_i;
    s_d.led_rd = rxd_i;
    s_d.led_rts = rts_dte_i;
    s_d.led_test = ber_test_i || loop_test_i;
    // error indicator multiplexed on test mode
    s_d.led_err = s_d.led_test ? bit_error_i : (s_d.tmr == TMR_STREAM);

    // sticky events; a new event wins over a clear in the same cycle
    ev_biterr = s_d.led_test && bit_error_i;
    s_d.irq_st = (s_q.irq_st & ~w1c) | {ev_biterr, ev_stream};
    s_d.irq = |(s_d.irq_st & s_d.irq_mk);
  end

  // single register for the whole state
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '{tmr: TMR_IDLE, presc: 16'h0000, ticks: 16'h0000,
               ctrl: `RTSAS_CTRL_RST, irq_st: `RTSAS_IRQ_RST,
               irq_mk: `RTSAS_IRQ_RST, pready: 1'b0, pslverr: 1'b0,
               prdata: `RTSAS_ZERO32, rts_out: 1'b0, dcd: 1'b0,
               tx_en: 1'b1, led_td: 1'b0, led_rd: 1'b0, led_rts: 1'b0,
               led_cd: 1'b0, led_test: 1'b0, led_err: 1'b0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign rts_int_o = s_q.rts_out;
  assign dcd_o = s_q.dcd;
  assign line_tx_en_o = s_q.tx_en;
  assign led_td_green_o = s_q.led_td;
  assign led_rd_green_o = s_q.led_rd;
  assign led_rts_green_o = s_q.led_rts;
  assign led_cd_green_o = s_q.led_cd;
  assign led_test_o = s_q.led_test;
  assign led_err_o = s_q.led_err;
  assign irq_o = s_q.irq;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  a_rts_passthru: assert property (sel == SEL_OFF ##0 sel == SEL_OFF |=>
      rts_int_o == $past(rts_dte_i))
    else $error("rts not passed through while timer disabled");

  // timer starts from zero on RTS
  a_timer_start: assert property (s_q.tmr == TMR_IDLE && sel != SEL_OFF &&
      rts_dte_i |=> s_q.tmr == TMR_TIMING && s_q.ticks == 16'h0000)
    else $error("timer did not start on raised rts");

  a_force_low: assert property (s_q.tmr == TMR_STREAM |-> !rts_int_o)
    else $error("internal rts high while streaming");

  // streaming shown on error indicator outside test
  a_err_stream: assert property (!led_test_o && s_q.tmr == TMR_STREAM
      |-> led_err_o)
    else $error("error indicator dark during streaming");

  // drop of RTS clears timer and indicator
  a_drop_clear: assert property (!rts_dte_i && !ber_test_i && !loop_test_i
      |=> s_q.tmr == TMR_IDLE && !led_err_o)
    else $error("rts drop did not clear the timer");

  // tick count never passes the selected limit
  a_tick_bound: assert property (s_q.tmr == TMR_TIMING |->
      s_q.ticks < lim && s_q.presc < 16'(PRESCALE))
    else $error("tick count beyond selected limit");

  // expiry only on the last tick of the nominal period
  a_no_early: assert property ($rose(s_q.tmr == TMR_STREAM) |->
      $past(s_q.ticks) >= $past(lim) - 16'h0001 &&
      $past(s_q.presc) == 16'(PRESCALE - 1))
    else $error("timeout before nominal period");

  a_test_err: assert property (ber_test_i || loop_test_i |=>
      led_err_o == $past(bit_error_i))
    else $error("error indicator does not follow bit errors in test");

  a_test_led: assert property (##1 led_test_o ==
      ($past(ber_test_i) || $past(loop_test_i)))
    else $error("test indicator wrong");

  // indicators and carrier detect follow their signals
  a_led_follow: assert property (##1 led_td_green_o == $past(txd_i) &&
      led_rd_green_o == $past(rxd_i) && led_rts_green_o == $past(rts_dte_i)
      && dcd_o == $past(line_carrier_i) && led_cd_green_o == dcd_o)
    else $error("indicator does not follow its line");

  a_carrier_mode: assert property (line_tx_en_o ==
      (s_q.ctrl[`RTSAS_CTRL_CARRIER] ? rts_int_o : 1'b1))
    else $error("line transmitter enable wrong for carrier mode");

  c_stream: cover property ($rose(s_q.tmr == TMR_STREAM));
  c_stream_release: cover property (s_q.tmr == TMR_STREAM ##1 s_q.tmr == TMR_IDLE);
  c_test_error: cover property (led_test_o && led_err_o);
  c_irq: cover property ($rose(irq_o));

endmodule : rtsas_top

// File: test/rtsas_dte_model.sv
// terminal model driving rts and transmit data toward the block
`timescale 1ns/10ps

module rtsas_dte_model (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic rts_req_i,
  input wire logic txd_req_i,
  output logic rts_o,
  output logic txd_o
);
  // ------------------------------------------------------------
  // line drivers
  // ------------------------------------------------------------
  // terminal lines idle low, like a real rs-232 device at rest
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rts_o <= 1'b0;
      txd_o <= 1'b0;
    end else begin
      rts_o <= rts_req_i;
      txd_o <= txd_req_i;
    end
  end
endmodule : rtsas_dte_model

// File: test/test_rts_anti_stream_status_leds.sv
// self-checking bench for the anti-stream timer and indicator block
`timescale 1ns/10ps
`include "rtsas_map.svh"
`define CHK(nm, ex, ac) n_compared++; if ((ac) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, ac); end

module test_rts_anti_stream_status_leds;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk_sys_i, reset_n_i, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic er_v, rts_req, txd_req, rts_dte, txd, rxd, carrier, ber, loop, biterr;
  logic rts_int, dcd, tx_en, l_td, l_rd, l_rts, l_cd, l_test, l_err, irq;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  logic [2:0] ctl_t [3] = '{3'b001, 3'b110, 3'b011};
  int nom_t [3] = '{20, 80, 20};

  rtsas_top #(.PRESCALE(4), .SHORT_TICKS(5), .LONG_TICKS(20)) dut_u (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rts_dte_i(rts_dte), .txd_i(txd),
    .rxd_i(rxd), .line_carrier_i(carrier), .ber_test_i(ber), .loop_test_i(loop),
    .bit_error_i(biterr), .rts_int_o(rts_int), .dcd_o(dcd), .line_tx_en_o(tx_en),
    .led_td_green_o(l_td), .led_rd_green_o(l_rd), .led_rts_green_o(l_rts),
    .led_cd_green_o(l_cd), .led_test_o(l_test), .led_err_o(l_err), .irq_o(irq));

  rtsas_dte_model dte_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .rts_req_i(rts_req), .txd_req_i(txd_req), .rts_o(rts_dte), .txd_o(txd));

  // ------------------------------------------------------------
  // clock, timeout and closing report
  // ------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // a hang counts as a mismatch; the run needs well under this
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask : tick

  // one apb transfer; the edge at entry keeps psel from two writes per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rts_req, txd_req, rxd, carrier, ber, loop, biterr} = '0;
    reset_n_i = 1'b0;
    tick(8);
    reset_n_i <= 1'b1;
    tick(2);
    // reset values and refused accesses
    `CHK("tx_en rst", 1'b1, tx_en)
    `CHK("err rst", 1'b0, l_err)
    apb(1'b0, `RTSAS_CTRL_OFS, 0);
    `CHK("ctrl rst", `RTSAS_ZERO32, rd_v)
    apb(1'b0, `RTSAS_IRQ_MK_OFS, 0);
    `CHK("mask rst", `RTSAS_ZERO32, rd_v)
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, er_v)
    `CHK("unmapped data", `RTSAS_ZERO32, rd_v)
    $display("test reset done");
    // every combination of rts, txd, rxd and carrier, timer off
    for (int i = 0; i < 16; i++) begin
      {rts_req, txd_req, rxd, carrier} <= i[3:0];
      tick(4);
      `CHK("led td", i[2], l_td)
      `CHK("led rd", i[1], l_rd)
      `CHK("led cd", i[0], l_cd)
      `CHK("dcd", i[0], dcd)
      `CHK("led rts", i[3], l_rts)
      `CHK("rts pass", i[3], rts_int)
    end
    // timer off: a long rts is never cut
    rts_req <= 1'b1;
    tick(150);
    `CHK("rts untimed", 1'b1, rts_int)
    `CHK("err untimed", 1'b0, l_err)
    rts_req <= 1'b0;
    tick(3);
    $display("test indicators done");
    // each enabled select code (short, long, short), carrier mode and mask
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, `RTSAS_IRQ_MK_OFS, {31'h0, ctl_t[j][0]});
      apb(1'b1, `RTSAS_CTRL_OFS, {29'h0, ctl_t[j]});
      rts_req <= 1'b1;
      @(posedge clk_sys_i);
      while (rts_dte !== 1'b1) @(posedge clk_sys_i);
      // gated rts rises one cycle after the line; count its high time
      while (rts_int !== 1'b1) @(posedge clk_sys_i);
      n = 0;
      while (rts_int !== 1'b0 && n < 200) begin
        @(posedge clk_sys_i);
        n++;
      end
      `CHK("not early", 1'b1, n >= nom_t[j])
      `CHK("not late", 1'b1, n <= nom_t[j] + nom_t[j] / 2)
      tick(2);
      `CHK("stream err", 1'b1, l_err)
      `CHK("carrier", !ctl_t[j][2], tx_en)
      `CHK("irq level", ctl_t[j][0], irq)
      apb(1'b0, `RTSAS_STAT_OFS, 0);
      `CHK("stat stream", 1'b1, rd_v[`RTSAS_STAT_STREAM])
      `CHK("stat rts", 1'b1, rd_v[`RTSAS_STAT_RTS])
      apb(1'b1, `RTSAS_IRQ_ST_OFS, 32'h0000_0001);
      apb(1'b0, `RTSAS_IRQ_ST_OFS, 0);
      `CHK("irq cleared", 1'b0, rd_v[`RTSAS_IRQ_STREAM])
      `CHK("irq low", 1'b0, irq)
      rts_req <= 1'b0;
      tick(4);
      `CHK("err off", 1'b0, l_err)
      `CHK("carrier idle", ctl_t[j][2] ? 1'b0 : 1'b1, tx_en)
    end
    $display("test stream timer done");
    // pattern test then loopback: error led shows bit errors
    for (int k = 0; k < 2; k++) begin
      {ber, loop} <= k ? 2'b01 : 2'b10;
      tick(3);
      `CHK("led test", 1'b1, l_test)
      biterr <= 1'b1;
      tick(3);
      `CHK("err biterr", 1'b1, l_err)
      biterr <= 1'b0;
      tick(3);
      `CHK("err clear", 1'b0, l_err)
      {ber, loop} <= 2'b00;
      tick(3);
      `CHK("led test off", 1'b0, l_test)
    end
    apb(1'b0, `RTSAS_IRQ_ST_OFS, 0);
    `CHK("biterr event", 1'b1, rd_v[`RTSAS_IRQ_BITERR])
    $display("test diagnostics done");
    finish_test();
  end
endmodule : test_rts_anti_stream_status_leds
